// *** rtl/sdadc_pkg.sv ***
// Constants, register map and types for the sigma-delta ADC mode control.
// Assumes a single 250 MHz clock domain and a classic Wishbone slave.
package sdadc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SDADC_OFS_MODE = 8'h00;
    localparam logic [7:0] SDADC_OFS_CONFIG = 8'h04;
    localparam logic [7:0] SDADC_OFS_STATUS = 8'h08;
    localparam logic [7:0] SDADC_OFS_FILTER = 8'h0C;
    localparam logic [7:0] SDADC_OFS_CUR_CTRL = 8'h10;
    localparam logic [7:0] SDADC_OFS_VOLT_CTRL = 8'h14;
    localparam logic [7:0] SDADC_OFS_CUR_RES = 8'h18;
    localparam logic [7:0] SDADC_OFS_VOLT_RES = 8'h1C;
    localparam logic [7:0] SDADC_OFS_MASK = 8'h20;
    localparam logic [7:0] SDADC_OFS_THRESH = 8'h24;
    localparam logic [7:0] SDADC_OFS_COUNT = 8'h28;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SDADC_MODE_LP_BIT = 3;
    localparam int SDADC_CFG_GNDSW_BIT = 7;
    localparam int SDADC_CTRL_EN_BIT = 19;
    localparam int SDADC_STA_CUR_RDY = 0;
    localparam int SDADC_STA_VOLT_RDY = 1;
    localparam int SDADC_STA_THR = 2;
    localparam int SDADC_STA_CNT = 3;
    localparam int SDADC_STA_VOLT_ERR = 12;
    localparam int SDADC_STA_CUR_ERR = 13;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SDADC_MODE_RST = 4'h3;
    localparam logic [15:0] SDADC_FILTER_RST = 16'h0007;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SDADC_CLK_KHZ = 250_000;
    localparam int SDADC_MOD_NORMAL_KHZ = 512;
    localparam int SDADC_MOD_LOWPWR_KHZ = 128;
    localparam int SDADC_DIV_NORMAL = SDADC_CLK_KHZ / SDADC_MOD_NORMAL_KHZ;
    localparam int SDADC_DIV_LOWPWR = SDADC_CLK_KHZ / SDADC_MOD_LOWPWR_KHZ;
    localparam int SDADC_SETTLE_CONV = 3;
    localparam int SDADC_VIN_SEL_COUNT = 5;

    typedef enum logic [2:0] {
        SDADC_MODE_PDOWN = 3'b000,
        SDADC_MODE_CONT = 3'b001,
        SDADC_MODE_SINGLE = 3'b010,
        SDADC_MODE_IDLE = 3'b011,
        SDADC_MODE_ZS_CAL = 3'b101,
        SDADC_MODE_FS_CAL = 3'b110
    } sdadc_mode_t;
endpackage

// *** rtl/sdadc_ctrl.sv ***
// Sigma-delta ADC mode control: modes, modulator clocking, status, results.
// Assumes modulator results arrive as same-clock strobes from the converter.
`timescale 1ns/1ps
`default_nettype none

module sdadc_ctrl
    import sdadc_pkg::*;
#(
    parameter int RES_W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cur_done,
    input wire logic [RES_W-1:0] cur_result,
    input wire logic cur_range_err,
    input wire logic volt_done,
    input wire logic [RES_W-1:0] volt_result,
    input wire logic volt_range_err,
    output logic mod_clk_en,
    output logic adc_hold_reset,
    output logic adc_power_on,
    output logic cur_enable,
    output logic volt_enable,
    output logic [2:0] volt_input_sel,
    output logic switched_ground_pin,
    output logic low_power_mode,
    output logic cal_zero,
    output logic cal_full,
    output logic wake_irq
);
    // Result path and register lanes are laid out for 20-bit results only
    if (RES_W != 20) begin : g_bad_res_w
        $error("RES_W must be 20");
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [3:0] mode_q, mode_d;
    logic [7:0] cfg_q, cfg_d;
    logic [15:0] filt_q, filt_d;
    logic [31:0] cctl_q, cctl_d, vctl_q, vctl_d;
    logic [RES_W-1:0] cres_q, cres_d, vres_q, vres_d;
    logic [15:0] sta_q, sta_d;
    logic [3:0] mask_q, mask_d;
    logic [RES_W-1:0] thr_q, thr_d;
    logic [15:0] cnt_lim_q, cnt_lim_d, cnt_q, cnt_d;
    logic [1:0] vsettle_q, vsettle_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [15:0] div_q, div_d;
    logic mclk_q, mclk_d;

    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wr = req && wb_we_i;
    wire logic rd = req && !wb_we_i;
    wire logic [2:0] mode_f = mode_q[2:0];
    // Continuous mode stays converting until software writes another mode
    wire logic converting = (mode_f == SDADC_MODE_CONT) || (mode_f == SDADC_MODE_SINGLE)
        || (mode_f == SDADC_MODE_ZS_CAL) || (mode_f == SDADC_MODE_FS_CAL);
    wire logic is_cal = (mode_f == SDADC_MODE_ZS_CAL) || (mode_f == SDADC_MODE_FS_CAL);
    wire logic cur_ev = cur_done && converting && cctl_q[SDADC_CTRL_EN_BIT];
    wire logic volt_ev = volt_done && converting && vctl_q[SDADC_CTRL_EN_BIT];
    wire logic volt_valid = volt_ev && (vsettle_q == 2'(SDADC_SETTLE_CONV - 1));

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        mode_d = mode_q;
        cfg_d = cfg_q;
        filt_d = filt_q;
        cctl_d = cctl_q;
        vctl_d = vctl_q;
        cres_d = cres_q;
        vres_d = vres_q;
        sta_d = sta_q;
        mask_d = mask_q;
        thr_d = thr_q;
        cnt_lim_d = cnt_lim_q;
        cnt_d = cnt_q;
        vsettle_d = vsettle_q;
        ack_d = req;
        rdat_d = rdat_q;
        // Register writes first so hardware events below win over clears
        if (wr) begin
            unique case (wb_adr_i)
                SDADC_OFS_MODE: begin
                    m = merge({28'h0, mode_q}, wb_dat_i, wb_sel_i);
                    mode_d = m[3:0];
                    cnt_d = 16'h0000;
                end
                SDADC_OFS_CONFIG: begin
                    m = merge({24'h0, cfg_q}, wb_dat_i, wb_sel_i);
                    cfg_d = m[7:0];
                end
                SDADC_OFS_FILTER: begin
                    m = merge({16'h0, filt_q}, wb_dat_i, wb_sel_i);
                    filt_d = m[15:0];
                end
                SDADC_OFS_CUR_CTRL: cctl_d = merge(cctl_q, wb_dat_i, wb_sel_i);
                SDADC_OFS_VOLT_CTRL: begin
                    vctl_d = merge(vctl_q, wb_dat_i, wb_sel_i);
                    vsettle_d = 2'b00;
                end
                SDADC_OFS_STATUS: begin
                    // Write one to clear
                    m = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
                    sta_d = sta_q & ~m[15:0];
                end
                SDADC_OFS_MASK: begin
                    m = merge({28'h0, mask_q}, wb_dat_i, wb_sel_i);
                    mask_d = m[3:0];
                end
                SDADC_OFS_THRESH: begin
                    m = merge({12'h0, thr_q}, wb_dat_i, wb_sel_i);
                    thr_d = m[RES_W-1:0];
                end
                SDADC_OFS_COUNT: begin
                    m = merge({16'h0, cnt_lim_q}, wb_dat_i, wb_sel_i);
                    cnt_lim_d = m[15:0];
                end
                default: ;
            endcase
        end
        if (rd) begin
            unique case (wb_adr_i)
                SDADC_OFS_MODE: rdat_d = {28'h0, mode_q};
                SDADC_OFS_CONFIG: rdat_d = {24'h0, cfg_q};
                SDADC_OFS_STATUS: rdat_d = {16'h0, sta_q};
                SDADC_OFS_FILTER: rdat_d = {16'h0, filt_q};
                SDADC_OFS_CUR_CTRL: rdat_d = cctl_q;
                SDADC_OFS_VOLT_CTRL: rdat_d = vctl_q;
                SDADC_OFS_CUR_RES: begin
                    rdat_d = {12'h0, cres_q};
                    sta_d[SDADC_STA_CUR_RDY] = 1'b0;
                end
                SDADC_OFS_VOLT_RES: begin
                    rdat_d = {12'h0, vres_q};
                    sta_d[SDADC_STA_VOLT_RDY] = 1'b0;
                end
                SDADC_OFS_MASK: rdat_d = {28'h0, mask_q};
                SDADC_OFS_THRESH: rdat_d = {12'h0, thr_q};
                SDADC_OFS_COUNT: rdat_d = {16'h0, cnt_lim_q};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
        // Current channel completion
        if (cur_ev) begin
            cres_d = cur_result;
            sta_d[SDADC_STA_CUR_RDY] = 1'b1;
            if (cur_range_err) sta_d[SDADC_STA_CUR_ERR] = 1'b1;
            if ($signed(cur_result) > $signed(thr_q)) sta_d[SDADC_STA_THR] = 1'b1;
            cnt_d = cnt_q + 16'h0001;
            if (cnt_lim_q != 16'h0000 && cnt_q + 16'h0001 >= cnt_lim_q) begin
                sta_d[SDADC_STA_CNT] = 1'b1;
                cnt_d = 16'h0000;
            end
        end
        // Voltage channel: results before settling are dropped
        if (volt_ev) begin
            if (!volt_valid) vsettle_d = vsettle_q + 2'b01;
            else begin
                vres_d = volt_result;
                sta_d[SDADC_STA_VOLT_RDY] = 1'b1;
                if (volt_range_err) sta_d[SDADC_STA_VOLT_ERR] = 1'b1;
            end
        end
        // Single conversion and calibration fall back to idle
        if ((mode_f == SDADC_MODE_SINGLE || is_cal) && (cur_ev || volt_valid)) begin
            mode_d = {mode_q[SDADC_MODE_LP_BIT], SDADC_MODE_IDLE};
        end
        if (!converting) vsettle_d = 2'b00;
    end

    // ------------------------------------------------------------
    // Modulator clock divider
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] lim;
        lim = mode_q[SDADC_MODE_LP_BIT] ? 16'(SDADC_DIV_LOWPWR / 2 - 1)
                                        : 16'(SDADC_DIV_NORMAL / 2 - 1);
        div_d = div_q + 16'h0001;
        mclk_d = mclk_q;
        if (!converting) begin
            div_d = 16'h0000;
            mclk_d = 1'b0;
        end else if (div_q >= lim) begin
            div_d = 16'h0000;
            mclk_d = !mclk_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= SDADC_MODE_RST;
            cfg_q <= 8'h00;
            filt_q <= SDADC_FILTER_RST;
            cctl_q <= 32'h0000_0000;
            vctl_q <= 32'h0000_0000;
            cres_q <= '0;
            vres_q <= '0;
            sta_q <= 16'h0000;
            mask_q <= 4'h0;
            thr_q <= '0;
            cnt_lim_q <= 16'h0000;
            cnt_q <= 16'h0000;
            vsettle_q <= 2'b00;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            div_q <= 16'h0000;
            mclk_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            cfg_q <= cfg_d;
            filt_q <= filt_d;
            cctl_q <= cctl_d;
            vctl_q <= vctl_d;
            cres_q <= cres_d;
            vres_q <= vres_d;
            sta_q <= sta_d;
            mask_q <= mask_d;
            thr_q <= thr_d;
            cnt_lim_q <= cnt_lim_d;
            cnt_q <= cnt_d;
            vsettle_q <= vsettle_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            div_q <= div_d;
            mclk_q <= mclk_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign mod_clk_en = mclk_q;
    assign adc_hold_reset = !converting;
    assign adc_power_on = (mode_f != SDADC_MODE_PDOWN);
    assign cur_enable = cctl_q[SDADC_CTRL_EN_BIT] && adc_power_on;
    assign volt_enable = vctl_q[SDADC_CTRL_EN_BIT] && adc_power_on;
    // Codes above four select the diagnostic pair
    assign volt_input_sel = (vctl_q[2:0] >= 3'(SDADC_VIN_SEL_COUNT)) ? 3'h4 : vctl_q[2:0];
    assign switched_ground_pin = cfg_q[SDADC_CFG_GNDSW_BIT];
    assign low_power_mode = mode_q[SDADC_MODE_LP_BIT];
    assign cal_zero = (mode_f == SDADC_MODE_ZS_CAL);
    assign cal_full = (mode_f == SDADC_MODE_FS_CAL);
    assign wake_irq = |(sta_q[3:0] & mask_q);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_single_to_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_f == SDADC_MODE_SINGLE && cur_ev && !wr) |=> mode_f == SDADC_MODE_IDLE)
        else $error("single conversion did not return to idle");
    a_cur_ready_set: assert property (@(posedge clk) disable iff (!rst_n)
        cur_ev |=> sta_q[SDADC_STA_CUR_RDY] && cres_q == $past(cur_result))
        else $error("current ready or result missing");
    a_cur_err_set: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_ev && cur_range_err) |=> sta_q[SDADC_STA_CUR_ERR])
        else $error("current range error not flagged");
    a_ground_switch: assert property (@(posedge clk) disable iff (!rst_n)
        switched_ground_pin == cfg_q[7])
        else $error("ground switch mismatch");
    a_lp_select: assert property (@(posedge clk) disable iff (!rst_n)
        low_power_mode == mode_q[3])
        else $error("low power select mismatch");
    a_idle_reset: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_f == SDADC_MODE_IDLE) |-> adc_hold_reset && adc_power_on)
        else $error("idle mode not held in reset");
    a_volt_unsettled: assert property (@(posedge clk) disable iff (!rst_n)
        (volt_ev && vsettle_q == 2'b00) |=> !$rose(sta_q[SDADC_STA_VOLT_RDY]))
        else $error("unsettled voltage result flagged");
    a_ready_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (sta_q[SDADC_STA_CUR_RDY] && !req) |=> sta_q[SDADC_STA_CUR_RDY])
        else $error("ready flag dropped without read");
    a_mux_range: assert property (@(posedge clk) disable iff (!rst_n)
        volt_input_sel < 3'(SDADC_VIN_SEL_COUNT))
        else $error("voltage mux code out of range");
    a_thr_wake: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_ev && mask_q[SDADC_STA_THR] && $signed(cur_result) > $signed(thr_q)) |=> wake_irq)
        else $error("threshold wake missing");
endmodule

`default_nettype wire

// *** test/sdadc_ctrl_tb.sv ***
// Self-checking bench for the ADC mode control block.
// Assumes the hand-over contract: ack one cycle after the taking edge, done pulses one cycle.
`timescale 1ns/1ps
`default_nettype none

module sdadc_ctrl_tb;
    import sdadc_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cur_done = 1'b0, cur_range_err = 1'b0, volt_done = 1'b0, volt_range_err = 1'b0;
    logic [19:0] cur_result = 20'h0_0000, volt_result = 20'h0_0000;
    logic mod_clk_en, adc_hold_reset, adc_power_on, cur_enable, volt_enable;
    logic [2:0] volt_input_sel;
    logic switched_ground_pin, low_power_mode, cal_zero, cal_full, wake_irq;
    int num_errors = 0;
    int n_checks = 0;
    int cyc_cnt = 0;
    integer seed = 32'h7cf4;
    logic [31:0] q;
    logic [19:0] r;
    int p;

    always #2 clk = ~clk;

    sdadc_ctrl dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cur_done(cur_done),
        .cur_result(cur_result), .cur_range_err(cur_range_err), .volt_done(volt_done),
        .volt_result(volt_result), .volt_range_err(volt_range_err), .mod_clk_en(mod_clk_en),
        .adc_hold_reset(adc_hold_reset), .adc_power_on(adc_power_on),
        .cur_enable(cur_enable), .volt_enable(volt_enable), .volt_input_sel(volt_input_sel),
        .switched_ground_pin(switched_ground_pin), .low_power_mode(low_power_mode),
        .cal_zero(cal_zero), .cal_full(cal_full), .wake_irq(wake_irq));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Ceiling covers fifteen low-power modulator periods plus margin
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            num_errors++;
            $display("BAD %0t run did not finish in time", $time);
            tally_and_finish();
        end
    end

    function automatic logic [31:0] exp_sel(input int code);
        return (code >= SDADC_VIN_SEL_COUNT) ? 32'd4 : code;
    endfunction

    // ------------------------------------------------------------
    // Bus and converter drivers
    // ------------------------------------------------------------
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
            $display("BAD %0t no bus answer", $time);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        wb_xfer(1'b0, a, 32'h0000_0000);
    endtask

    task automatic done_pulse(input bit volt, input logic [19:0] res, input logic err);
        if (volt) begin
            volt_done <= 1'b1;
            volt_result <= res;
            volt_range_err <= err;
        end else begin
            cur_done <= 1'b1;
            cur_result <= res;
            cur_range_err <= err;
        end
        @(posedge clk);
        volt_done <= 1'b0;
        cur_done <= 1'b0;
        volt_range_err <= 1'b0;
        cur_range_err <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Rising edge to rising edge of the modulator clock, in system cycles
    task automatic mod_period(input int div);
        int n;
        n = 0;
        p = 0;
        while (mod_clk_en !== 1'b0 && n < 5000) begin @(posedge clk); n++; end
        while (mod_clk_en !== 1'b1 && n < 5000) begin @(posedge clk); n++; end
        while (mod_clk_en === 1'b1 && p < 5000) begin @(posedge clk); p++; end
        while (mod_clk_en === 1'b0 && p < 5000) begin @(posedge clk); p++; end
        check({31'b0, (p >= div - 2) && (p <= div + 2)}, 32'd1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({30'b0, adc_hold_reset, adc_power_on}, 32'd3);
        rd(SDADC_OFS_MODE);
        check(q & 32'hF, 32'h3);
        rd(SDADC_OFS_FILTER);
        check(q & 32'hFFFF, 32'h0007);
        rd(8'h3C);
        check(q, 32'h0000_0000);
        $display("test reset done");

        wr(SDADC_OFS_CONFIG, 32'h0000_0080);
        check({31'b0, switched_ground_pin}, 32'd1);
        wr(SDADC_OFS_CONFIG, 32'h0000_0000);
        check({31'b0, switched_ground_pin}, 32'd0);
        for (int c = 0; c < 8; c++) begin
            wr(SDADC_OFS_VOLT_CTRL, 32'h0008_0000 | c);
            check({29'b0, volt_input_sel}, exp_sel(c));
            check({31'b0, volt_enable}, 32'd1);
        end
        $display("test config done");

        // Idle first, then channel setup, then the mode write
        wr(SDADC_OFS_MODE, 32'h3);
        wr(SDADC_OFS_CUR_CTRL, 32'h0008_0000);
        check({31'b0, adc_power_on}, 32'd1);
        repeat (25) @(posedge clk); // Settling wait shortened for run time
        wr(SDADC_OFS_MODE, 32'h2);
        check({31'b0, adc_hold_reset}, 32'd0);
        r = $random(seed);
        done_pulse(1'b0, r, 1'b0);
        rd(SDADC_OFS_MODE);
        check(q & 32'h7, 32'h3);
        rd(SDADC_OFS_STATUS);
        check(q & 32'h1, 32'h1);
        rd(SDADC_OFS_CUR_RES);
        check(q & 32'hF_FFFF, {12'b0, r});
        rd(SDADC_OFS_STATUS);
        check(q & 32'h1, 32'h0);
        $display("test single done");

        wr(SDADC_OFS_MODE, 32'h1);
        mod_period(SDADC_DIV_NORMAL);
        r = 20'($random(seed));
        done_pulse(1'b0, r, 1'b1);
        r = $random(seed);
        done_pulse(1'b0, r, 1'b0);
        rd(SDADC_OFS_STATUS);
        check((q >> SDADC_STA_CUR_ERR) & 32'h1, 32'h1);
        rd(SDADC_OFS_MODE);
        check(q & 32'h7, 32'h1);
        check({31'b0, adc_hold_reset}, 32'd0);
        rd(SDADC_OFS_CUR_RES);
        check(q & 32'hF_FFFF, {12'b0, r});
        wr(SDADC_OFS_STATUS, 32'hFFFF_FFFF);
        rd(SDADC_OFS_STATUS);
        check(q & 32'h3003, 32'h0);
        wr(SDADC_OFS_VOLT_CTRL, 32'h0008_0002);
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            done_pulse(1'b1, r, k == 2);
            rd(SDADC_OFS_STATUS);
            check((q >> SDADC_STA_VOLT_RDY) & 32'h1, (k == 2) ? 32'd1 : 32'd0);
        end
        check((q >> SDADC_STA_VOLT_ERR) & 32'h1, 32'h1);
        rd(SDADC_OFS_VOLT_RES);
        check(q & 32'hF_FFFF, {12'b0, r});
        $display("test continuous done");

        wr(SDADC_OFS_MODE, 32'h9);
        check({30'b0, low_power_mode, adc_hold_reset}, 32'd2);
        mod_period(SDADC_DIV_LOWPWR);
        wr(SDADC_OFS_STATUS, 32'hFFFF_FFFF);
        wr(SDADC_OFS_THRESH, 32'h0000_0100);
        wr(SDADC_OFS_MASK, 32'h4);
        done_pulse(1'b0, 20'h0_0200, 1'b0);
        check({31'b0, wake_irq}, 32'd1);
        wr(SDADC_OFS_STATUS, 32'hF);
        check({31'b0, wake_irq}, 32'd0);
        wr(SDADC_OFS_MASK, 32'h8);
        wr(SDADC_OFS_COUNT, 32'h2);
        wr(SDADC_OFS_MODE, 32'h9);
        done_pulse(1'b0, 20'h0_0000, 1'b0);
        done_pulse(1'b0, 20'h0_0000, 1'b0);
        check({31'b0, wake_irq}, 32'd1);
        $display("test low power done");

        for (int m = 5; m <= 6; m++) begin
            wr(SDADC_OFS_MODE, m);
            check({30'b0, cal_zero, cal_full}, (m == 5) ? 32'd2 : 32'd1);
            r = $random(seed);
            done_pulse(1'b0, r, 1'b0);
            rd(SDADC_OFS_MODE);
            check(q & 32'h7, 32'h3);
            rd(SDADC_OFS_CUR_RES);
            check(q & 32'hF_FFFF, {12'b0, r});
        end
        $display("test calibration done");

        wr(SDADC_OFS_MASK, 32'h0);
        wr(SDADC_OFS_VOLT_CTRL, 32'h0);
        wr(SDADC_OFS_CUR_CTRL, 32'h0);
        wr(SDADC_OFS_MODE, 32'h0);
        check({29'b0, adc_power_on, cur_enable, volt_enable}, 32'd0);
        wr(SDADC_OFS_VOLT_CTRL, 32'h0008_0000);
        wr(SDADC_OFS_CUR_CTRL, 32'h0008_0000);
        wr(SDADC_OFS_MODE, 32'h3);
        check({29'b0, adc_power_on, cur_enable, volt_enable}, 32'd7);
        $display("test power cycle done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
